// File: omd_bank.sv
/*
  Parameter and diagnostic record bank of an eight-channel digital output
  module, reached by record set, CANopen index or Ethernet subindex.
  Assumes fault inputs come from asynchronous detection circuits and the
  request port from logic on clk_sys.
*/
`timescale 1ns/1ps
`include "omd_regs.svh"

module omd_bank
  import omd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        sys_stopped,
  input  wire logic [7:0]  slot_number,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire omd_kind_t   req_kind,
  input  wire logic [15:0] req_object,
  input  wire logic [7:0]  req_sub,
  input  wire logic [4:0]  req_byte,
  input  wire logic [7:0]  req_wdata,
  input  wire logic        module_fail_pin,
  input  wire logic        comm_error_pin,
  input  wire logic        aux_missing_pin,
  input  wire logic [7:0]  short_high_pin,
  input  wire logic [7:0]  short_low_pin,
  input  wire logic [7:0]  wire_break_pin,
  output wire logic        rsp_valid,
  output wire logic        rsp_error,
  output wire logic [7:0]  rsp_rdata,
  output wire logic [7:0]  wire_break_detect_en,
  output wire logic [7:0]  short_detect_en,
  output wire logic        diag_event
);

  localparam int NIN = 27;

  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic           mf_s;
  logic           comm_s;
  logic           aux_s;
  logic [7:0]     shi_s;
  logic [7:0]     slo_s;
  logic [7:0]     wb_s;

  // Two-stage synchroniser on every fault pin; only stage two is read.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= {module_fail_pin, comm_error_pin, aux_missing_pin,
                  short_high_pin, short_low_pin, wire_break_pin};
      sync2_q <= sync1_q;
    end
  end

  assign {mf_s, comm_s, aux_s, shi_s, slo_s, wb_s} = sync2_q;

  // Microsecond ticker with a cycle prescaler.
  logic [6:0]  pre_q;
  logic [6:0]  pre_d;
  logic [31:0] tick_q;
  logic [31:0] tick_d;
  logic        us_wrap;

  always_comb begin
    us_wrap = (pre_q == 7'(`OMD_US_CYCLES - 1));
    pre_d   = us_wrap ? 7'h00 : 7'(pre_q + 7'h01);
    tick_d  = us_wrap ? 32'(tick_q + 32'h1) : tick_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_q  <= '0;
      tick_q <= '0;
    end else if (ce) begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  // Parameter bytes.
  logic [7:0] diag_interrupt_enable_q;
  logic [7:0] wire_break_enable_q;
  logic [7:0] short_detect_enable_q;

  // Live diagnostic state.
  logic       diag_on;
  logic       param_err;
  logic [7:0] wb_f;
  logic [7:0] shi_f;
  logic [7:0] slo_f;
  logic [7:0] detail_d [8];
  logic [7:0] map_d;
  logic [7:0] err_a_d;
  logic [7:0] err_d_d;
  logic       new_fault;

  logic [7:0] detail_q [8];
  logic [7:0] map_q;
  logic [7:0] err_a_q;
  logic [7:0] err_d_q;
  logic [31:0] stamp_q;
  logic [31:0] stamp_d;
  logic       event_q;

  // Builds the fault picture from the enables and the synchronised pins.
  always_comb begin
    diag_on   = (diag_interrupt_enable_q == `OMD_DIAG_ON);
    param_err = (diag_interrupt_enable_q != `OMD_DIAG_OFF) && !diag_on;
    wb_f      = wb_s & wire_break_enable_q;
    shi_f     = shi_s & short_detect_enable_q;
    slo_f     = slo_s & short_detect_enable_q;
    new_fault = 1'b0;
    for (int i = 0; i < 8; i++) begin
      // Reserved bits 1 and 7..5 stay zero.
      detail_d[i] = {3'b000, wb_f[i], slo_f[i], shi_f[i], 1'b0, param_err};
      map_d[i]    = |detail_d[i];
      new_fault   = new_fault | (|(detail_d[i] & ~detail_q[i]));
    end
    err_a_d = {param_err, 2'b00, aux_s, |map_d,
               aux_s | (|map_d), mf_s | comm_s, mf_s};
    err_d_d = {3'b000, comm_s, 4'h0};
    if (!diag_on) begin
      // A parameter error shows as 80h in the first error byte; all else reads zero.
      err_a_d = param_err ? {1'b1, 7'h00} : 8'h00;
      err_d_d = 8'h00;
      map_d   = 8'h00;
      for (int i = 0; i < 8; i++) begin
        detail_d[i] = 8'h00;
      end
    end
    new_fault = diag_on &&
                (new_fault || |((err_a_d & ~err_a_q) | (err_d_d & ~err_d_q)));
    stamp_d   = new_fault ? tick_q : stamp_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      map_q   <= '0;
      err_a_q <= '0;
      err_d_q <= '0;
      stamp_q <= '0;
      event_q <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        detail_q[i] <= '0;
      end
    end else if (ce) begin
      map_q   <= map_d;
      err_a_q <= err_a_d;
      err_d_q <= err_d_d;
      stamp_q <= stamp_d;
      event_q <= new_fault;
      for (int i = 0; i < 8; i++) begin
        detail_q[i] <= detail_d[i];
      end
    end
  end

  // Record image as the controller sees it.
  logic [7:0] rec [20];

  always_comb begin
    rec[`OMD_R_ERR_A]   = err_a_q;
    rec[`OMD_R_MODINFO] = `OMD_MODINFO;
    rec[`OMD_R_RSVD]    = 8'h00;
    rec[`OMD_R_ERR_D]   = err_d_q;
    rec[`OMD_R_KIND]    = `OMD_CHAN_KIND;
    rec[`OMD_R_BITS]    = `OMD_DIAG_BITS;
    rec[`OMD_R_CHANS]   = `OMD_CHAN_COUNT;
    rec[`OMD_R_MAP]     = map_q;
    for (int i = 0; i < 8; i++) begin
      rec[`OMD_R_DETAIL + 5'(i)] = detail_q[i];
    end
    for (int i = 0; i < 4; i++) begin
      rec[`OMD_R_STAMP + 5'(i)] = stamp_q[8*i +: 8];
    end
  end

  // Request decode.
  logic       hit;
  logic       is_param;
  logic [1:0] pidx;
  logic [4:0] rbyte;
  logic [4:0] rlen;
  logic [15:0] eth_param;

  always_comb begin
    hit       = 1'b0;
    is_param  = 1'b0;
    pidx      = 2'd0;
    rbyte     = req_byte;
    rlen      = `OMD_R_LEN;
    eth_param = 16'(`OMD_IX_PARAM + {8'h00, slot_number});
    case (req_kind)
      OMD_KIND_RECSET: begin
        if (req_object == {8'h00, `OMD_DS_PARAM} && req_write) begin
          is_param = (req_byte < `OMD_P_COUNT);
          pidx     = req_byte[1:0];
          hit      = is_param;
        end else if (req_object == {8'h00, `OMD_DS_PARAM}) begin
          rlen = `OMD_R_SHORT_LEN;
          hit  = 1'b1;
        end else if (req_object == {8'h00, `OMD_DS_DIAG}) begin
          hit  = 1'b1;
        end
      end
      OMD_KIND_CANIX: begin
        if (req_object >= `OMD_IX_PARAM &&
            req_object < 16'(`OMD_IX_PARAM + 16'(`OMD_P_COUNT))) begin
          is_param = 1'b1;
          pidx     = req_object[1:0];
          hit      = 1'b1;
        end else if (req_object == `OMD_IX_DIAG_SHORT) begin
          rlen = `OMD_R_SHORT_LEN;
          hit  = 1'b1;
        end else if (req_object == `OMD_IX_DIAG_FULL) begin
          hit  = 1'b1;
        end
      end
      OMD_KIND_ETHSX: begin
        if (req_object == eth_param && req_sub >= `OMD_SX_PARAM_LO &&
            req_sub <= `OMD_SX_PARAM_HI) begin
          is_param = 1'b1;
          pidx     = 2'(req_sub - `OMD_SX_PARAM_LO);
          hit      = 1'b1;
        end else if (req_object == `OMD_SX_DIAG &&
                     req_sub >= `OMD_SX_BYTE_LO &&
                     req_sub <= `OMD_SX_BYTE_HI) begin
          rbyte = 5'(req_sub - `OMD_SX_BYTE_LO);
          hit   = 1'b1;
        end else if (req_object == `OMD_SX_DIAG &&
                     req_sub == `OMD_SX_STAMP) begin
          rbyte = 5'(`OMD_R_STAMP + {3'b000, req_byte[1:0]});
          hit   = 1'b1;
        end
      end
      default: hit = 1'b0;
    endcase
    if (!is_param && rbyte >= rlen) begin
      hit = 1'b0;
    end
  end

  // Parameter writes and the one-cycle answer.
  logic [7:0] diag_interrupt_enable_d;
  logic [7:0] wire_break_enable_d;
  logic [7:0] short_detect_enable_d;
  logic       rsp_valid_q;
  logic       rsp_valid_d;
  logic       rsp_error_q;
  logic       rsp_error_d;
  logic [7:0] rsp_rdata_q;
  logic [7:0] rsp_rdata_d;
  logic       wr_ok;

  always_comb begin
    diag_interrupt_enable_d = diag_interrupt_enable_q;
    wire_break_enable_d     = wire_break_enable_q;
    short_detect_enable_d   = short_detect_enable_q;
    rsp_valid_d = req_valid;
    rsp_error_d = 1'b0;
    rsp_rdata_d = 8'h00;
    // Parameter writes outside the stopped state are refused.
    wr_ok = req_valid && req_write && hit && is_param && sys_stopped;
    if (req_valid) begin
      if (!hit || (req_write && !wr_ok)) begin
        rsp_error_d = 1'b1;
      end else if (!req_write && is_param) begin
        case (pidx)
          `OMD_P_DIAG: rsp_rdata_d = diag_interrupt_enable_q;
          `OMD_P_WB:   rsp_rdata_d = wire_break_enable_q;
          `OMD_P_SC:   rsp_rdata_d = short_detect_enable_q;
          default:     rsp_rdata_d = 8'h00;
        endcase
      end else if (!req_write) begin
        rsp_rdata_d = rec[rbyte];
      end
    end
    if (wr_ok) begin
      case (pidx)
        `OMD_P_DIAG: diag_interrupt_enable_d = req_wdata;
        `OMD_P_WB:   wire_break_enable_d     = req_wdata;
        `OMD_P_SC:   short_detect_enable_d   = req_wdata;
        default:     diag_interrupt_enable_d = diag_interrupt_enable_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diag_interrupt_enable_q <= `OMD_PARAM_RST;
      wire_break_enable_q     <= `OMD_PARAM_RST;
      short_detect_enable_q   <= `OMD_PARAM_RST;
      rsp_valid_q             <= 1'b0;
      rsp_error_q             <= 1'b0;
      rsp_rdata_q             <= 8'h00;
    end else if (ce) begin
      diag_interrupt_enable_q <= diag_interrupt_enable_d;
      wire_break_enable_q     <= wire_break_enable_d;
      short_detect_enable_q   <= short_detect_enable_d;
      rsp_valid_q             <= rsp_valid_d;
      rsp_error_q             <= rsp_error_d;
      rsp_rdata_q             <= rsp_rdata_d;
    end
  end

  assign rsp_valid            = rsp_valid_q;
  assign rsp_error            = rsp_error_q;
  assign rsp_rdata            = rsp_rdata_q;
  assign wire_break_detect_en = wire_break_enable_q;
  assign short_detect_en      = short_detect_enable_q;
  assign diag_event           = event_q;

  // Helper views for the checks below.
  logic [7:0] wb_seen;
  logic [7:0] sc_seen;
  logic [7:0] map_calc;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wb_seen[i]  = detail_q[i][4];
      sc_seen[i]  = detail_q[i][2] | detail_q[i][3];
      map_calc[i] = |detail_q[i];
    end
  end

  property p_tick;
    @(posedge clk_sys) disable iff (rst)
      (ce && us_wrap) |=> (tick_q == 32'($past(tick_q) + 32'h1));
  endproperty
  a_tick: assert property (p_tick) else $error("Ticker missed a step.");

  property p_diag_off;
    @(posedge clk_sys) disable iff (rst)
      (diag_interrupt_enable_q == `OMD_DIAG_OFF) |=> (map_q == 8'h00);
  endproperty
  a_diag_off: assert property (p_diag_off) else $error("Map set while off.");

  property p_wb_gate;
    @(posedge clk_sys) disable iff (rst)
      ##1 ((wb_seen & ~$past(wire_break_enable_q)) == 8'h00);
  endproperty
  a_wb_gate: assert property (p_wb_gate) else $error("Wire-break ungated.");

  property p_sc_gate;
    @(posedge clk_sys) disable iff (rst)
      ##1 ((sc_seen & ~$past(short_detect_enable_q)) == 8'h00);
  endproperty
  a_sc_gate: assert property (p_sc_gate) else $error("Short flag ungated.");

  property p_ds_short;
    @(posedge clk_sys) disable iff (rst)
      (ce && req_valid && !req_write && req_kind == OMD_KIND_RECSET &&
       req_object == 16'h0000 && req_byte == 5'd4) |=> rsp_valid && rsp_error;
  endproperty
  a_ds_short: assert property (p_ds_short) else $error("Byte 4 of set 0.");

  property p_can_full;
    @(posedge clk_sys) disable iff (rst)
      (ce && req_valid && !req_write && req_kind == OMD_KIND_CANIX &&
       req_object == `OMD_IX_DIAG_FULL && req_byte == `OMD_R_KIND)
      |=> rsp_valid && !rsp_error && rsp_rdata == `OMD_CHAN_KIND;
  endproperty
  a_can_full: assert property (p_can_full) else $error("Bad 2F01h read.");

  property p_eth_first;
    @(posedge clk_sys) disable iff (rst)
      (ce && req_valid && !req_write && req_kind == OMD_KIND_ETHSX &&
       req_object == `OMD_SX_DIAG && req_sub == `OMD_SX_BYTE_LO)
      |=> rsp_valid && rsp_rdata == $past(err_a_q);
  endproperty
  a_eth_first: assert property (p_eth_first) else $error("Bad 5005h read.");

  property p_param_wr;
    @(posedge clk_sys) disable iff (rst)
      (ce && req_valid && req_write && req_kind == OMD_KIND_CANIX &&
       req_object == 16'h3101 && sys_stopped)
      |=> !rsp_error && wire_break_enable_q == $past(req_wdata);
  endproperty
  a_param_wr: assert property (p_param_wr) else $error("Bad 3101h write.");

  property p_run_refuse;
    @(posedge clk_sys) disable iff (rst)
      (ce && req_valid && req_write && !sys_stopped)
      |=> rsp_error && $stable(diag_interrupt_enable_q);
  endproperty
  a_run_refuse: assert property (p_run_refuse) else $error("Write in run.");

  property p_summary;
    @(posedge clk_sys) disable iff (rst)
      (err_a_q[3] == |map_q) && (err_a_q[6:5] == 2'b00) && (map_q == map_calc);
  endproperty
  a_summary: assert property (p_summary) else $error("Summary mismatch.");

  property p_stamp;
    @(posedge clk_sys) disable iff (rst)
      (ce && new_fault) |=> (stamp_q == $past(tick_q)) && diag_event;
  endproperty
  a_stamp: assert property (p_stamp) else $error("Stamp not taken.");

  c_event: cover property (@(posedge clk_sys) disable iff (rst) event_q);
  c_refuse: cover property (@(posedge clk_sys) disable iff (rst)
    rsp_valid && rsp_error);
  c_wb: cover property (@(posedge clk_sys) disable iff (rst) |wb_seen);

endmodule : omd_bank

// File: omd_ctrl_model.sv
/*
  Behavioural backplane controller that moves single bytes to and from
  the record bank, promptly or after idle cycles.
  Assumes the bank answers within three clock edges of a taken request.
*/
`timescale 1ns/1ps

module omd_ctrl_model
  import omd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_error,
  input  wire logic [7:0]  rsp_rdata,
  output logic             sys_stopped,
  output logic             req_valid,
  output logic             req_write,
  output omd_kind_t        req_kind,
  output logic [15:0]      req_object,
  output logic [7:0]       req_sub,
  output logic [4:0]       req_byte,
  output logic [7:0]       req_wdata
);
  // Idle request lines and a stopped system from time zero.
  initial begin
    sys_stopped = 1'b1;
    req_valid   = 1'b0;
    req_write   = 1'b0;
    req_kind    = OMD_KIND_RECSET;
    req_object  = 16'h0000;
    req_sub     = 8'h00;
    req_byte    = 5'd0;
    req_wdata   = 8'h00;
  end

  // Parameter bytes are only accepted while the system is stopped.
  task automatic set_stopped(input logic v);
    @(posedge clk_sys);
    #1;
    sys_stopped = v;
  endtask : set_stopped

  // One byte transfer; gap idle cycles make a slow controller.
  task automatic xfer(input logic wr, input omd_kind_t kind,
                      input logic [15:0] obj, input logic [7:0] sub,
                      input logic [4:0] byt, input logic [7:0] wd,
                      input int gap, output logic [7:0] rd,
                      output logic err);
    rd  = 'x;
    err = 'x;
    repeat (gap + 1) @(posedge clk_sys);
    #1;
    req_write  = wr;
    req_kind   = kind;
    req_object = obj;
    req_sub    = sub;
    req_byte   = byt;
    req_wdata  = wd;
    req_valid  = 1'b1;
    @(posedge clk_sys);
    #1;
    req_valid  = 1'b0;
    req_object = ~obj;  // Released object and write data stop showing old values.
    req_wdata  = ~wd;
    for (int i = 0; i < 3; i++) begin
      if (rsp_valid === 1'b1) begin
        rd  = rsp_rdata;
        err = rsp_error;
        break;
      end
      @(posedge clk_sys);
      #1;
    end
  endtask : xfer
endmodule : omd_ctrl_model

// File: omd_pkg.sv
/*
  Types of the output-module diagnostic record bank.
  Assumes omd_regs.svh sits in the include path.
*/
package omd_pkg;
  // Addressing scheme of a request.
  typedef enum logic [1:0] {
    OMD_KIND_RECSET = 2'b00,
    OMD_KIND_CANIX  = 2'b01,
    OMD_KIND_ETHSX  = 2'b10
  } omd_kind_t;
endpackage : omd_pkg

// File: omd_regs.svh
/*
  Constants of the output-module diagnostic record bank: object numbers,
  record layout, fixed descriptor values and timing counts.
  Assumes inclusion by the bank module only, not by omd_pkg.sv.
*/
`ifndef OMD_REGS_SVH
`define OMD_REGS_SVH

// Record-set numbers.
`define OMD_DS_PARAM      8'h00
`define OMD_DS_DIAG       8'h01
// CANopen indices.
`define OMD_IX_PARAM      16'h3100
`define OMD_IX_DIAG_SHORT 16'h2f00
`define OMD_IX_DIAG_FULL  16'h2f01
// Industrial Ethernet diagnostic index, parameter subentries and diagnostic subentries.
`define OMD_SX_DIAG       16'h5005
`define OMD_SX_PARAM_LO   8'h01
`define OMD_SX_PARAM_HI   8'h03
`define OMD_SX_BYTE_LO    8'h02
`define OMD_SX_BYTE_HI    8'h11
`define OMD_SX_STAMP      8'h13
// Parameter byte positions.
`define OMD_P_DIAG        2'd0
`define OMD_P_WB          2'd1
`define OMD_P_SC          2'd2
`define OMD_P_COUNT       5'd3
// Diagnostic record layout.
`define OMD_R_ERR_A       5'd0
`define OMD_R_MODINFO     5'd1
`define OMD_R_RSVD        5'd2
`define OMD_R_ERR_D       5'd3
`define OMD_R_KIND        5'd4
`define OMD_R_BITS        5'd5
`define OMD_R_CHANS       5'd6
`define OMD_R_MAP         5'd7
`define OMD_R_DETAIL      5'd8
`define OMD_R_STAMP       5'd16
`define OMD_R_SHORT_LEN   5'd4
`define OMD_R_LEN         5'd20
// Parameter values and fixed descriptors.
`define OMD_DIAG_OFF      8'h00
`define OMD_DIAG_ON       8'h40
`define OMD_PARAM_RST     8'h00
`define OMD_MODINFO       8'h1f
`define OMD_CHAN_KIND     8'h72
`define OMD_DIAG_BITS     8'h08
`define OMD_CHAN_COUNT    8'h08
// Timing: one microsecond at the 10 ns system clock.
`define OMD_US_NS         1000
`define OMD_CLK_NS        10
`define OMD_US_CYCLES     (`OMD_US_NS / `OMD_CLK_NS)

`endif

// File: tb_output_module_diag_records.sv
/*
  Self-checking testbench of the output-module diagnostic record bank.
  Assumes omd_pkg and the controller model are compiled before it.
*/
`timescale 1ns/1ps

module tb_output_module_diag_records
  import omd_pkg::*;
  ;
  localparam omd_kind_t k_ds  = OMD_KIND_RECSET;
  localparam omd_kind_t k_can = OMD_KIND_CANIX;
  localparam omd_kind_t k_eth = OMD_KIND_ETHSX;

  logic        clk_sys;
  logic        rst;
  logic        ce;
  logic        sys_stopped;
  logic [7:0]  slot_number;
  logic        req_valid;
  logic        req_write;
  omd_kind_t   req_kind;
  logic [15:0] req_object;
  logic [7:0]  req_sub;
  logic [4:0]  req_byte;
  logic [7:0]  req_wdata;
  logic        module_fail_pin;
  logic        comm_error_pin;
  logic        aux_missing_pin;
  logic [7:0]  short_high_pin;
  logic [7:0]  short_low_pin;
  logic [7:0]  wire_break_pin;
  logic        rsp_valid;
  logic        rsp_error;
  logic [7:0]  rsp_rdata;
  logic [7:0]  wire_break_detect_en;
  logic [7:0]  short_detect_en;
  logic        diag_event;
  int          bad_count;
  int          total_checks;
  int          cyc;
  int          ev_count;
  int          ev_cyc;
  int          slow;

  // Bank under test and the controller on its request port.
  omd_bank dut (.clk_sys, .rst, .ce, .sys_stopped, .slot_number, .req_valid,
    .req_write, .req_kind, .req_object, .req_sub, .req_byte, .req_wdata,
    .module_fail_pin, .comm_error_pin, .aux_missing_pin, .short_high_pin,
    .short_low_pin, .wire_break_pin, .rsp_valid, .rsp_error, .rsp_rdata,
    .wire_break_detect_en, .short_detect_en, .diag_event);
  omd_ctrl_model ctl (.clk_sys, .rsp_valid, .rsp_error, .rsp_rdata,
    .sys_stopped, .req_valid, .req_write, .req_kind, .req_object, .req_sub,
    .req_byte, .req_wdata);

  // 100 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Cycles since reset release and the cycle of each diagnostic event.
  always @(posedge clk_sys) begin
    cyc <= rst ? 0 : cyc + 1;
    if (diag_event === 1'b1) begin
      ev_count <= ev_count + 1;
      ev_cyc   <= cyc;
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Read one byte and judge data and error flag.
  task automatic rdx(input string what, input omd_kind_t k,
                     input logic [15:0] obj, input logic [7:0] sub,
                     input logic [4:0] b, input logic [7:0] exp_d,
                     input logic exp_e);
    logic [7:0] d;
    logic       e;
    ctl.xfer(1'b0, k, obj, sub, b, 8'h00, slow, d, e);
    check({what, " data"}, {24'h0, d}, {24'h0, exp_d});
    check({what, " error"}, {31'h0, e}, {31'h0, exp_e});
  endtask : rdx

  // Write one byte and judge the error flag; written answers carry 00h.
  task automatic wrx(input string what, input omd_kind_t k,
                     input logic [15:0] obj, input logic [7:0] sub,
                     input logic [4:0] b, input logic [7:0] wd,
                     input logic exp_e);
    logic [7:0] d;
    logic       e;
    ctl.xfer(1'b1, k, obj, sub, b, wd, slow, d, e);
    check({what, " error"}, {31'h0, e}, {31'h0, exp_e});
  endtask : wrx

  task automatic settle;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : settle

  // Assemble the four timestamp bytes, least significant first.
  task automatic rd_stamp(output logic [31:0] s);
    logic [7:0] d;
    logic       e;
    for (int i = 0; i < 4; i++) begin
      ctl.xfer(1'b0, k_ds, 16'h0001, 8'h00, 5'(16 + i), 8'h00, 0, d, e);
      s[8*i +: 8] = d;
    end
  endtask : rd_stamp

  // Fresh bank: parameter defaults, fixed descriptors, zero elsewhere.
  task automatic t_reset;
    logic [7:0] e;
    check("wb out", {24'h0, wire_break_detect_en}, 32'h0);
    check("sc out", {24'h0, short_detect_en}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      rdx("param", k_can, 16'h3100 + 16'(i), 8'h00, 5'd0, 8'h00, 0);
    end
    for (int i = 0; i < 20; i++) begin
      e = (i == 1) ? 8'h1f : (i == 4) ? 8'h72 :
          (i == 5 || i == 6) ? 8'h08 : 8'h00;
      rdx("rec", k_ds, 16'h0001, 8'h00, 5'(i), e, 0);
    end
    $display("Test reset done");
  endtask : t_reset

  // Parameter paths, refusals and record lengths per addressing scheme.
  task automatic t_params;
    slow = 3;
    wrx("wb wr", k_can, 16'h3101, 8'h00, 5'd0, 8'h55, 0);
    check("wb out", {24'h0, wire_break_detect_en}, 32'h55);
    wrx("sc wr", k_eth, 16'h3103, 8'h03, 5'd0, 8'ha5, 0);
    check("sc out", {24'h0, short_detect_en}, 32'ha5);
    slow = 0;
    wrx("en wr", k_ds, 16'h0000, 8'h00, 5'd0, 8'h40, 0);
    rdx("en can", k_can, 16'h3100, 8'h00, 5'd0, 8'h40, 0);
    rdx("wb eth", k_eth, 16'h3103, 8'h02, 5'd0, 8'h55, 0);
    rdx("slot", k_eth, 16'h3100, 8'h01, 5'd0, 8'h00, 1);
    ctl.set_stopped(1'b0);
    wrx("run wr", k_can, 16'h3101, 8'h00, 5'd0, 8'hff, 1);
    ctl.set_stopped(1'b1);
    check("run wb", {24'h0, wire_break_detect_en}, 32'h55);
    wrx("diag wr", k_can, 16'h2f01, 8'h00, 5'd0, 8'h00, 1);
    rdx("unmapped", k_can, 16'h1234, 8'h00, 5'd0, 8'h00, 1);
    rdx("ds0 b3", k_ds, 16'h0000, 8'h00, 5'd3, 8'h00, 0);
    rdx("ds0 b4", k_ds, 16'h0000, 8'h00, 5'd4, 8'h00, 1);
    rdx("ds1 b20", k_ds, 16'h0001, 8'h00, 5'd20, 8'h00, 1);
    rdx("ix0 b3", k_can, 16'h2f00, 8'h00, 5'd3, 8'h00, 0);
    rdx("ix0 b4", k_can, 16'h2f00, 8'h00, 5'd4, 8'h00, 1);
    rdx("ix1 b4", k_can, 16'h2f01, 8'h00, 5'd4, 8'h72, 0);
    rdx("sx03", k_eth, 16'h5005, 8'h03, 5'd0, 8'h1f, 0);
    rdx("sx06", k_eth, 16'h5005, 8'h06, 5'd0, 8'h72, 0);
    rdx("sx12", k_eth, 16'h5005, 8'h12, 5'd0, 8'h00, 1);
    $display("Test params done");
  endtask : t_params

  // Fault pins against detection enables, summaries and enable byte.
  task automatic t_faults;
    wire_break_pin = 8'hff;
    settle();
    for (int i = 0; i < 8; i++) begin
      rdx("detail", k_ds, 16'h0001, 8'h00, 5'(8 + i),
          (i % 2) ? 8'h00 : 8'h10, 0);
    end
    rdx("map", k_ds, 16'h0001, 8'h00, 5'd7, 8'h55, 0);
    rdx("sum wb", k_ds, 16'h0001, 8'h00, 5'd0, 8'h0c, 0);
    wire_break_pin = 8'h00;
    short_high_pin = 8'h01;
    short_low_pin  = 8'h06;
    settle();
    rdx("sx0a", k_eth, 16'h5005, 8'h0a, 5'd0, 8'h04, 0);
    rdx("sx0b", k_eth, 16'h5005, 8'h0b, 5'd0, 8'h00, 0);
    rdx("sx0c", k_eth, 16'h5005, 8'h0c, 5'd0, 8'h08, 0);
    rdx("sx09", k_eth, 16'h5005, 8'h09, 5'd0, 8'h05, 0);
    short_high_pin  = 8'h00;
    short_low_pin   = 8'h00;
    module_fail_pin = 1'b1;
    settle();
    rdx("fail", k_can, 16'h2f00, 8'h00, 5'd0, 8'h03, 0);
    module_fail_pin = 1'b0;
    comm_error_pin  = 1'b1;
    settle();
    rdx("comm a", k_can, 16'h2f00, 8'h00, 5'd0, 8'h02, 0);
    rdx("comm d", k_can, 16'h2f00, 8'h00, 5'd3, 8'h10, 0);
    comm_error_pin  = 1'b0;
    aux_missing_pin = 1'b1;
    settle();
    rdx("aux", k_eth, 16'h5005, 8'h02, 5'd0, 8'h14, 0);
    wire_break_pin = 8'hff;
    wrx("bad en", k_can, 16'h3100, 8'h00, 5'd0, 8'h12, 0);
    settle();
    rdx("perr", k_ds, 16'h0001, 8'h00, 5'd0, 8'h80, 0);
    rdx("perr ch", k_ds, 16'h0001, 8'h00, 5'd8, 8'h00, 0);
    wrx("off", k_can, 16'h3100, 8'h00, 5'd0, 8'h00, 0);
    settle();
    rdx("off a", k_ds, 16'h0001, 8'h00, 5'd0, 8'h00, 0);
    rdx("off map", k_ds, 16'h0001, 8'h00, 5'd7, 8'h00, 0);
    aux_missing_pin = 1'b0;
    wire_break_pin  = 8'h00;
    wrx("on", k_can, 16'h3100, 8'h00, 5'd0, 8'h40, 0);
    settle();
    $display("Test faults done");
  endtask : t_faults

  // Timestamp capture on an event and ticker spacing between two events.
  task automatic t_stamp;
    logic [31:0] s1;
    logic [31:0] s2;
    logic [31:0] s3;
    int          n;
    int          c1;
    n = ev_count;
    wire_break_pin = 8'h01;
    settle();
    check("event", 32'(ev_count - n), 32'h1);
    c1 = ev_cyc;
    rd_stamp(s1);
    check("stamp", {31'h0, s1 >= 32'(c1 / 100 - 1) &&
                           s1 <= 32'(c1 / 100 + 1)}, 32'h1);
    repeat (300) @(posedge clk_sys);
    #1;
    rd_stamp(s3);
    check("held", s3, s1);
    wire_break_pin = 8'h00;
    repeat (2000) @(posedge clk_sys);
    #1;
    wire_break_pin = 8'h01;
    settle();
    rd_stamp(s2);
    n = (ev_cyc - c1) / 100;
    check("tick", {31'h0, s2 - s1 >= 32'(n - 1) &&
                          s2 - s1 <= 32'(n + 1)}, 32'h1);
    $display("Test stamp done");
  endtask : t_stamp

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // Reset for 16 cycles, then the scenarios in order.
  initial begin
    ce              = 1'b1;
    rst             = 1'b1;
    slot_number     = 8'h03;
    module_fail_pin = 1'b0;
    comm_error_pin  = 1'b0;
    aux_missing_pin = 1'b0;
    short_high_pin  = 8'h00;
    short_low_pin   = 8'h00;
    wire_break_pin  = 8'h00;
    bad_count       = 0;
    total_checks    = 0;
    cyc             = 0;
    ev_count        = 0;
    ev_cyc          = 0;
    slow            = 0;
    repeat (16) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
    t_params();
    t_faults();
    t_stamp();
    stop_test();
  end

  // The scenarios need about 2500 cycles; cut a hang at 20000.
  initial begin
    #200000;
    bad_count++;
    $display("FAIL watchdog expected finish seen hang");
    stop_test();
  end
endmodule : tb_output_module_diag_records
